/* File: tb/fbm_flash_bus_props.sv */
module fbm_flash_bus_props (
    input wire logic clk,
    input wire logic rstn,
    input wire logic device_reset_low,
    input wire logic chip_select_low,
    input wire logic output_enable_low,
    input wire logic program_enable_supply,
    input wire logic data_oe,
    input wire logic done_indicator_pin,
    input wire logic async_page_mode,
    input wire logic arr_prog,
    input wire logic arr_erase,
    input wire logic arr_invalidate
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    ////////////////////////////////////////////////////////////////////////////////
    property p_reset_float;
        !device_reset_low |-> !data_oe;
    endproperty
    a_reset_float: assert property (p_reset_float) else $error("bus driven in reset");
    property p_read_drive;
        device_reset_low && !chip_select_low && !output_enable_low |-> data_oe;
    endproperty
    a_read_drive: assert property (p_read_drive) else $error("read not driven");
    property p_oe_float;
        output_enable_low |-> !data_oe;
    endproperty
    a_oe_float: assert property (p_oe_float) else $error("driven without oe");
    property p_standby;
        chip_select_low |-> !data_oe;
    endproperty
    a_standby: assert property (p_standby) else $error("driven while deselected");
    property p_rst_mode;
        !device_reset_low |=> async_page_mode;
    endproperty
    a_rst_mode: assert property (p_rst_mode) else $error("not async page after reset");
    // idle reset must be over by the time the minimum pulse has passed
    property p_idle_reset;
        done_indicator_pin ##1 !device_reset_low [*5] ##1 device_reset_low
            |-> ##[0:1] done_indicator_pin;
    endproperty
    a_idle_reset: assert property (p_idle_reset) else $error("idle reset slow");
    property p_lockout;
        !program_enable_supply [*8] |-> !(arr_prog || arr_erase);
    endproperty
    a_lockout: assert property (p_lockout) else $error("array altered at lockout");
    // falling pin while not ready means an operation was running
    property p_abort;
        $fell(device_reset_low) && !$past(done_indicator_pin) |-> ##[1:1000] arr_invalidate;
    endproperty
    a_abort: assert property (p_abort) else $error("abort shutdown too slow");
    property p_deselect_run;
        arr_prog ##1 (chip_select_low && device_reset_low) [*8] |-> !done_indicator_pin;
    endproperty
    a_deselect_run: assert property (p_deselect_run) else $error("op stopped");

    c_prog: cover property (arr_prog);
    c_abort: cover property (arr_invalidate);
    c_read: cover property (data_oe ##1 !data_oe);
endmodule // fbm_flash_bus_props

/* File: tb/fbm_flash_bus_tb.sv */
module fbm_flash_bus_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int AW = 24;

    logic          clk = 1'b0;
    logic          rstn = 1'b0;
    logic          rst_l, cs_l, oe_l, we_l, supply;
    logic [AW-1:0] addr, arr_rd_addr, arr_addr, last_addr;
    logic [15:0]   data_in, data_out, arr_wdata, last_data, v;
    logic          data_oe, done_indicator_pin, low_power, async_page_mode;
    logic          arr_prog, arr_erase, arr_invalidate, arr_inval_block, inval_blk;
    int            error_cnt = 0, n_checks = 0, cyc = 0, prog_cnt = 0, inval_cnt = 0;
    int            erase_cnt = 0;

    always #10 clk = ~clk;

    ////////////////////////////////////////////////////////////////////////////////
    fbm_host_model #(.AW(AW)) host (.clk(clk), .data_out(data_out),
        .device_reset_low(rst_l), .chip_select_low(cs_l), .output_enable_low(oe_l),
        .write_strobe_low(we_l), .program_enable_supply(supply), .addr(addr),
        .data_in(data_in));

    // short busy times keep the run brief
    fbm_flash_bus #(.AW(AW), .PROG_CYC(20), .ERASE_CYC(40)) uut (.clk(clk), .rstn(rstn),
        .device_reset_low(rst_l), .chip_select_low(cs_l), .output_enable_low(oe_l),
        .write_strobe_low(we_l), .addr(addr), .data_in(data_in), .data_out(data_out),
        .data_oe(data_oe), .program_enable_supply(supply),
        .done_indicator_pin(done_indicator_pin), .low_power(low_power),
        .async_page_mode(async_page_mode), .arr_rd_addr(arr_rd_addr),
        .arr_rdata(arr_rd_addr[15:0] ^ 16'h5A5A), .arr_prog(arr_prog),
        .arr_erase(arr_erase), .arr_addr(arr_addr), .arr_wdata(arr_wdata),
        .arr_invalidate(arr_invalidate), .arr_inval_block(arr_inval_block));

    always @(posedge clk) begin
        cyc++;
        if (arr_prog === 1'b1) begin
            prog_cnt++;
            last_addr = arr_addr;
            last_data = arr_wdata;
        end
        if (arr_erase === 1'b1) begin
            erase_cnt++;
        end
        if (arr_invalidate === 1'b1) begin
            inval_cnt++;
            inval_blk = arr_inval_block;
        end
        if (cyc == 20000) begin
            error_cnt++;
            summarize();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic summarize();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic wait_done();
        for (int i = 0; i < 1500 && done_indicator_pin !== 1'b1; i++) @(negedge clk);
    endtask

    task automatic rd_chk(input logic [AW-1:0] a, input logic [15:0] exp);
        host.rd(a, v);
        chk(v, exp);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_program();
        int p0;
        p0 = prog_cnt;
        host.wr(0, 16'h0040, 0);
        host.wr(24'h00ABCD, 16'hBEEF, 0);
        // stay deselected long enough for the run-on check to see it
        repeat (10) @(negedge clk);
        chk(prog_cnt, p0 + 1);
        chk(last_addr, 24'h00ABCD);
        chk(last_data, 16'hBEEF);
        rd_chk(0, 16'h0000);
        chk(done_indicator_pin, 0);
        chk(low_power, 0);
        wait_done();
        rd_chk(0, 16'h0080);
    endtask

    task automatic t_lockout();
        int p0;
        p0 = prog_cnt;
        host.set_supply(1'b0);
        host.wr(0, 16'h0040, 0);
        host.wr(24'h000300, 16'h1234, 0);
        repeat (2) @(negedge clk);
        chk(prog_cnt, p0);
        host.wr(0, 16'h0070, 0);
        rd_chk(0, 16'h0098);
        host.wr(0, 16'h0050, 0);
        host.wr(0, 16'h0070, 0);
        rd_chk(0, 16'h0080);
        host.set_supply(1'b1);
    endtask

    task automatic t_abort(input bit erase);
        int i0;
        int e0;
        i0 = inval_cnt;
        e0 = erase_cnt;
        host.wr(24'h010040, erase ? 16'h0020 : 16'h0040, 0);
        host.wr(24'h010040, erase ? 16'h00D0 : 16'h4321, 0);
        @(negedge clk);
        chk(erase_cnt, e0 + erase);
        chk(done_indicator_pin, 0);
        host.pin_reset(5);
        wait_done();
        @(negedge clk);
        chk(inval_cnt, i0 + 1);
        chk(inval_blk, erase);
        rd_chk(24'h000077, 16'h0077 ^ 16'h5A5A);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (4) @(negedge clk);
        rstn = 1'b1;
        @(negedge clk);
        chk({data_oe, done_indicator_pin, async_page_mode, low_power}, 4'b0111);
        rd_chk(24'h000123, 16'h0123 ^ 16'h5A5A);
        host.wr(0, 16'h0070, 0);
        rd_chk(0, 16'h0080);
        t_program();
        host.wr(0, 16'h00FF, 0);
        host.wr(0, 16'h0070, 1);
        rd_chk(24'h000055, 16'h0055 ^ 16'h5A5A);
        t_lockout();
        host.wr(0, 16'h0060, 0);
        host.wr(0, 16'h0003, 0);
        @(negedge clk);
        chk(async_page_mode, 0);
        host.pin_reset(5);
        @(negedge clk);
        chk({async_page_mode, done_indicator_pin}, 2'b11);
        t_abort(0);
        t_abort(1);
        summarize();
    end
endmodule // fbm_flash_bus_tb

bind fbm_flash_bus fbm_flash_bus_props u_props (.clk(clk), .rstn(rstn),
    .device_reset_low(device_reset_low), .chip_select_low(chip_select_low),
    .output_enable_low(output_enable_low), .program_enable_supply(program_enable_supply),
    .data_oe(data_oe), .done_indicator_pin(done_indicator_pin),
    .async_page_mode(async_page_mode), .arr_prog(arr_prog), .arr_erase(arr_erase),
    .arr_invalidate(arr_invalidate));

/* File: tb/fbm_host_model.sv */
module fbm_host_model #(
    parameter int AW = 24
) (
    input  wire logic          clk,
    input  wire logic [15:0]   data_out,
    output logic               device_reset_low      = 1'b1,
    output logic               chip_select_low       = 1'b1,
    output logic               output_enable_low     = 1'b1,
    output logic               write_strobe_low      = 1'b1,
    output logic               program_enable_supply = 1'b1,
    output logic [AW-1:0]      addr                  = '0,
    output logic [15:0]        data_in               = 16'h0000
);
    timeunit 1ns;
    timeprecision 1ps;

    ////////////////////////////////////////////////////////////////////////////////
    // clash holds oe low with the strobe, which a well-behaved host never does
    task automatic wr(input logic [AW-1:0] a, input logic [15:0] d, input bit clash);
        @(negedge clk);
        addr = a;
        data_in = d;
        chip_select_low = 1'b0;
        write_strobe_low = 1'b0;
        output_enable_low = !clash;
        repeat (2) @(negedge clk);
        write_strobe_low = 1'b1;
        chip_select_low = 1'b1;
        output_enable_low = 1'b1;
        // released lines must not keep the last value
        data_in = ~d;
        addr = ~a;
        @(negedge clk);
    endtask

    task automatic rd(input logic [AW-1:0] a, output logic [15:0] d);
        @(negedge clk);
        addr = a;
        chip_select_low = 1'b0;
        output_enable_low = 1'b0;
        repeat (2) @(negedge clk);
        d = data_out;
        chip_select_low = 1'b1;
        output_enable_low = 1'b1;
        addr = ~a;
    endtask

    task automatic set_supply(input logic lvl);
        program_enable_supply = lvl;
    endtask

    task automatic pin_reset(input int n);
        @(negedge clk);
        device_reset_low = 1'b0;
        repeat (n) @(negedge clk);
        device_reset_low = 1'b1;
    endtask
endmodule // fbm_host_model

/* File: verilog/fbm_flash_bus.sv */
`include "fbm_params.svh"

module fbm_flash_bus #(
    parameter int AW         = 24,
    parameter int PROG_CYC   = `FBM_PROG_CYC,
    parameter int ERASE_CYC  = `FBM_ERASE_CYC
) (
    input  wire logic          clk,
    input  wire logic          rstn,
    input  wire logic          device_reset_low,
    input  wire logic          chip_select_low,
    input  wire logic          output_enable_low,
    input  wire logic          write_strobe_low,
    input  wire logic [AW-1:0] addr,
    input  wire logic [15:0]   data_in,
    output logic      [15:0]   data_out,
    output logic               data_oe,
    input  wire logic          program_enable_supply,
    output logic               done_indicator_pin,
    output logic               low_power,
    output logic               async_page_mode,
    output logic [AW-1:0]      arr_rd_addr,
    input  wire logic [15:0]   arr_rdata,
    output logic               arr_prog,
    output logic               arr_erase,
    output logic [AW-1:0]      arr_addr,
    output logic [15:0]        arr_wdata,
    output logic               arr_invalidate,
    output logic               arr_inval_block
);
    ////////////////////////////////////////////////////////////////////////////
    // pin decode

    wire logic in_reset  = ~device_reset_low;
    wire logic selected  = ~chip_select_low & device_reset_low;
    wire logic reading   = selected & ~output_enable_low;
    // write side stays blind while output enable is active
    wire logic wr_active = selected & ~write_strobe_low & output_enable_low;

    logic                        wr_act_r;
    logic [AW-1:0]               lat_addr_r;
    logic [15:0]                 lat_data_r;
    logic                        rd_status_r;
    logic [7:0]                  sr_r;
    logic                        page_async_r;
    logic [15:0]                 dout_r;
    fbm_pkg::fbm_cmd_state_t     cmd_r;
    fbm_pkg::fbm_cmd_state_t     cmd_nxt;
    logic                        start_prog;
    logic                        start_erase;
    logic                        seq_busy;
    logic                        seq_ruined;
    logic                        seq_ruined_blk;
    logic                        prog_r;
    logic                        erase_r;
    logic [AW-1:0]               arr_addr_r;
    logic [15:0]                 arr_wdata_r;

    // capture on whichever of select or strobe rises first
    wire logic wr_end  = wr_act_r & (chip_select_low | write_strobe_low) &
                         output_enable_low & device_reset_low;
    wire logic [7:0] cmd_byte = lat_data_r[7:0];
    wire logic supply_ok      = program_enable_supply;

    ////////////////////////////////////////////////////////////////////////////
    // write capture, sampled levels only

    // the last sampled values before the rising edge are the ones latched
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wr_act_r   <= 1'b0;
            lat_addr_r <= '0;
            lat_data_r <= 16'h0000;
        end else begin
            wr_act_r <= wr_active;
            if (wr_active) begin
                lat_addr_r <= addr;
                lat_data_r <= data_in;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // command front end

    wire logic is_read_array = (cmd_byte == `FBM_CMD_READ_ARRAY);
    wire logic is_read_stat  = (cmd_byte == `FBM_CMD_READ_STATUS);
    wire logic is_clear_stat = (cmd_byte == `FBM_CMD_CLEAR_STATUS);
    wire logic is_prog       = (cmd_byte == `FBM_CMD_PROG_A) | (cmd_byte == `FBM_CMD_PROG_B);
    wire logic is_erase      = (cmd_byte == `FBM_CMD_ERASE);
    wire logic is_confirm    = (cmd_byte == `FBM_CMD_CONFIRM);
    wire logic is_config     = (cmd_byte == `FBM_CMD_CONFIG);
    wire logic is_cfg_read   = (cmd_byte == `FBM_CMD_CFG_READ);

    wire logic in_prog_data  = (cmd_r == fbm_pkg::FBM_CMD_PROG_DATA);
    wire logic in_erase_conf = (cmd_r == fbm_pkg::FBM_CMD_ERASE_CONF);
    wire logic in_cfg_data   = (cmd_r == fbm_pkg::FBM_CMD_CFG_DATA);

    // a second cycle while the sequencer runs is dropped, not queued
    wire logic arm_ok    = wr_end & ~seq_busy & supply_ok;
    wire logic lock_hit  = wr_end & ~seq_busy & ~supply_ok &
                           (in_prog_data | (in_erase_conf & is_confirm));
    wire logic bad_seq   = wr_end & in_erase_conf & ~is_confirm;
    assign start_prog    = arm_ok & in_prog_data;
    assign start_erase   = arm_ok & in_erase_conf & is_confirm;
    wire logic go_status = start_prog | start_erase | lock_hit | bad_seq |
                           (wr_end & cmd_r == fbm_pkg::FBM_CMD_IDLE & is_read_stat);
    wire logic go_array  = wr_end & cmd_r == fbm_pkg::FBM_CMD_IDLE & is_read_array;
    wire logic do_clear  = wr_end & cmd_r == fbm_pkg::FBM_CMD_IDLE & is_clear_stat;
    wire logic do_cfg    = wr_end & in_cfg_data & is_cfg_read;

    // the address is only carried along; it never selects the front end
    always_comb begin
        cmd_nxt = cmd_r;
        if (wr_end) begin
            unique case (cmd_r)
                fbm_pkg::FBM_CMD_IDLE: begin
                    if (is_prog) begin
                        cmd_nxt = fbm_pkg::FBM_CMD_PROG_DATA;
                    end else if (is_erase) begin
                        cmd_nxt = fbm_pkg::FBM_CMD_ERASE_CONF;
                    end else if (is_config) begin
                        cmd_nxt = fbm_pkg::FBM_CMD_CFG_DATA;
                    end
                end
                fbm_pkg::FBM_CMD_PROG_DATA,
                fbm_pkg::FBM_CMD_ERASE_CONF,
                fbm_pkg::FBM_CMD_CFG_DATA: begin
                    cmd_nxt = fbm_pkg::FBM_CMD_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // mode, status and configuration

    wire logic [7:0] sr_err_set = {2'b00, lock_hit & in_erase_conf | bad_seq,
                                   lock_hit & in_prog_data | bad_seq,
                                   lock_hit, 3'b000};
    wire logic [7:0] sr_clr     = do_clear ?
                                  ((8'h01 << `FBM_SR_ERASE_ERR) | (8'h01 << `FBM_SR_PROG_ERR) |
                                   (8'h01 << `FBM_SR_SUPPLY_LOW)) : 8'h00;
    wire logic [7:0] status     = {~seq_busy, sr_r[6:0]};

    // error set beats a clear arriving in the same cycle
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cmd_r        <= fbm_pkg::FBM_CMD_IDLE;
            rd_status_r  <= 1'b0;
            sr_r         <= `FBM_SR_RESET;
            page_async_r <= 1'b1;
        end else if (in_reset) begin
            // held every cycle of the reset pulse, so done on its first edge
            cmd_r        <= fbm_pkg::FBM_CMD_IDLE;
            rd_status_r  <= 1'b0;
            sr_r         <= `FBM_SR_RESET;
            page_async_r <= 1'b1;
        end else begin
            cmd_r <= cmd_nxt;
            if (go_status) begin
                rd_status_r <= 1'b1;
            end else if (go_array) begin
                rd_status_r <= 1'b0;
            end
            sr_r <= (sr_r & ~sr_clr) | sr_err_set;
            if (do_cfg) begin
                page_async_r <= lat_addr_r[`FBM_CFG_MODE_BIT];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // array launch

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            prog_r      <= 1'b0;
            erase_r     <= 1'b0;
            arr_addr_r  <= '0;
            arr_wdata_r <= 16'h0000;
        end else begin
            prog_r  <= start_prog;
            erase_r <= start_erase;
            if (start_prog | start_erase) begin
                arr_addr_r  <= lat_addr_r;
                arr_wdata_r <= lat_data_r;
            end
        end
    end

    // deselect does not reach the sequencer, so operations run on
    fbm_write_sequencer #(
        .CW         (32),
        .PROG_CYC   (PROG_CYC),
        .ERASE_CYC  (ERASE_CYC),
        .PROG_SHUT  (`FBM_PROG_SHUT_CYC),
        .ERASE_SHUT (`FBM_ERASE_SHUT_CYC)
    ) u_seq (
        .clk          (clk),
        .rstn         (rstn),
        .start_prog   (start_prog),
        .start_erase  (start_erase),
        .abort        (in_reset),
        .busy         (seq_busy),
        .done         (),
        .ruined       (seq_ruined),
        .ruined_block (seq_ruined_blk)
    );

    ////////////////////////////////////////////////////////////////////////////
    // read path and pins

    // read data refreshes every cycle, standby adds no latency
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            dout_r <= 16'h0000;
        end else begin
            dout_r <= rd_status_r ? {8'h00, status} : arr_rdata;
        end
    end

    assign data_out           = dout_r;
    assign data_oe            = reading & ~in_reset;
    assign arr_rd_addr        = addr;
    // ready-high indicator; also low while reset shutdown is still running
    assign done_indicator_pin = ~seq_busy & ~in_reset;
    assign low_power          = (in_reset | chip_select_low) & ~seq_busy;
    assign async_page_mode    = page_async_r;
    assign arr_prog           = prog_r;
    assign arr_erase          = erase_r;
    assign arr_addr           = arr_addr_r;
    assign arr_wdata          = arr_wdata_r;
    assign arr_invalidate     = seq_ruined;
    assign arr_inval_block    = seq_ruined_blk;
endmodule // fbm_flash_bus

/* File: verilog/fbm_params.svh */
`ifndef FBM_PARAMS_SVH
`define FBM_PARAMS_SVH

// clock and timing
`define FBM_CLK_MHZ          50
`define FBM_RST_MIN_NS       100
`define FBM_RST_IDLE_CYC     ((`FBM_RST_MIN_NS * `FBM_CLK_MHZ) / 1000)
`define FBM_ERASE_SHUT_US    20
`define FBM_PROG_SHUT_US     10
`define FBM_ERASE_SHUT_CYC   (`FBM_ERASE_SHUT_US * `FBM_CLK_MHZ)
`define FBM_PROG_SHUT_CYC    (`FBM_PROG_SHUT_US * `FBM_CLK_MHZ)
`define FBM_PROG_TIME_US     150
`define FBM_ERASE_TIME_MS    1000
`define FBM_PROG_CYC         (`FBM_PROG_TIME_US * `FBM_CLK_MHZ)
`define FBM_ERASE_CYC        (`FBM_ERASE_TIME_MS * 1000 * `FBM_CLK_MHZ)

// status register
`define FBM_SR_RESET         8'h80
`define FBM_SR_READY         7
`define FBM_SR_ERASE_ERR     5
`define FBM_SR_PROG_ERR      4
`define FBM_SR_SUPPLY_LOW    3

// command codes
`define FBM_CMD_READ_ARRAY   8'hFF
`define FBM_CMD_READ_STATUS  8'h70
`define FBM_CMD_CLEAR_STATUS 8'h50
`define FBM_CMD_PROG_A       8'h40
`define FBM_CMD_PROG_B       8'h10
`define FBM_CMD_ERASE        8'h20
`define FBM_CMD_CONFIRM      8'hD0
`define FBM_CMD_CONFIG       8'h60
`define FBM_CMD_CFG_READ     8'h03
`define FBM_CFG_MODE_BIT     15

`endif

/* File: verilog/fbm_pkg.sv */
package fbm_pkg;
    typedef enum logic [1:0] {
        FBM_CMD_IDLE,
        FBM_CMD_PROG_DATA,
        FBM_CMD_ERASE_CONF,
        FBM_CMD_CFG_DATA
    } fbm_cmd_state_t;

    typedef enum logic [1:0] {
        FBM_SEQ_IDLE,
        FBM_SEQ_PROG,
        FBM_SEQ_ERASE,
        FBM_SEQ_SHUT
    } fbm_seq_state_t;
endpackage

/* File: verilog/fbm_write_sequencer.sv */
`include "fbm_params.svh"

module fbm_write_sequencer #(
    parameter int CW         = 32,
    parameter int PROG_CYC   = `FBM_PROG_CYC,
    parameter int ERASE_CYC  = `FBM_ERASE_CYC,
    parameter int PROG_SHUT  = `FBM_PROG_SHUT_CYC,
    parameter int ERASE_SHUT = `FBM_ERASE_SHUT_CYC
) (
    input  wire logic clk,
    input  wire logic rstn,
    input  wire logic start_prog,
    input  wire logic start_erase,
    input  wire logic abort,
    output logic      busy,
    output logic      done,
    output logic      ruined,
    output logic      ruined_block
);
    fbm_pkg::fbm_seq_state_t state_r;
    fbm_pkg::fbm_seq_state_t state_nxt;
    logic [CW-1:0]           cnt_r;
    logic [CW-1:0]           cnt_nxt;
    logic                    blk_r;
    logic                    blk_nxt;
    logic                    done_nxt;
    logic                    ruined_nxt;

    wire logic cnt_end = (cnt_r == '0);

    always_comb begin
        state_nxt  = state_r;
        cnt_nxt    = cnt_end ? cnt_r : cnt_r - CW'(1);
        blk_nxt    = blk_r;
        done_nxt   = 1'b0;
        ruined_nxt = 1'b0;
        unique case (state_r)
            fbm_pkg::FBM_SEQ_IDLE: begin
                if (start_prog) begin
                    state_nxt = fbm_pkg::FBM_SEQ_PROG;
                    cnt_nxt   = CW'(PROG_CYC - 1);
                    blk_nxt   = 1'b0;
                end else if (start_erase) begin
                    state_nxt = fbm_pkg::FBM_SEQ_ERASE;
                    cnt_nxt   = CW'(ERASE_CYC - 1);
                    blk_nxt   = 1'b1;
                end
            end
            fbm_pkg::FBM_SEQ_PROG, fbm_pkg::FBM_SEQ_ERASE: begin
                // shutdown spans the whole allowed window, a worst case for the host
                if (abort) begin
                    state_nxt = fbm_pkg::FBM_SEQ_SHUT;
                    // minus two: the invalidate pulse is registered one edge after zero
                    cnt_nxt   = blk_r ? CW'(ERASE_SHUT - 2) : CW'(PROG_SHUT - 2);
                end else if (cnt_end) begin
                    state_nxt = fbm_pkg::FBM_SEQ_IDLE;
                    done_nxt  = 1'b1;
                end
            end
            fbm_pkg::FBM_SEQ_SHUT: begin
                if (cnt_end) begin
                    state_nxt  = fbm_pkg::FBM_SEQ_IDLE;
                    ruined_nxt = 1'b1;
                end
            end
        endcase
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_r <= fbm_pkg::FBM_SEQ_IDLE;
            cnt_r   <= '0;
            blk_r   <= 1'b0;
            done    <= 1'b0;
            ruined  <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
            blk_r   <= blk_nxt;
            done    <= done_nxt;
            ruined  <= ruined_nxt;
        end
    end

    assign busy         = (state_r != fbm_pkg::FBM_SEQ_IDLE);
    assign ruined_block = blk_r;
endmodule // fbm_write_sequencer
